// ===== hw/afmc_map.svh
// register indices, field positions, reset values and codes of the buffer
`ifndef AFMC_MAP_SVH
`define AFMC_MAP_SVH
// register indices; byte address is four times the index
`define AFMC_IDX_CTRL     6'h28
`define AFMC_IDX_CNT_LO   6'h29
`define AFMC_IDX_STATUS   6'h2C
`define AFMC_IDX_MASK     6'h2D
`define AFMC_IDX_DATA     6'h2E
`define AFMC_IDX_ENTRIES  6'h2F
// reset values
`define AFMC_RST_CTRL     8'h00
`define AFMC_RST_CNT_LO   8'h80
`define AFMC_RST_MASK     3'h0
// buffering policy codes
`define AFMC_MODE_OFF     2'h0
`define AFMC_MODE_KEEP    2'h1
`define AFMC_MODE_STREAM  2'h2
`define AFMC_MODE_TRIG    2'h3
// status and mask bit positions
`define AFMC_ST_LEVEL     0
`define AFMC_ST_OVERRUN   1
`define AFMC_ST_CAPTURED  2
`endif

// ===== hw/afmc_pkg.sv
// types shared by the sample buffer control block
`default_nettype none
package afmc_pkg;
  typedef struct packed {
    logic       rsvd;
    logic [3:0] chan_sel;
    logic       cnt_msb;
    logic [1:0] mode;
  } afmc_ctrl_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } afmc_sample_t;
  typedef enum logic [1:0] {TRIG_ARMED, TRIG_FILL, TRIG_DONE} afmc_trig_t;
endpackage
`default_nettype wire

// ===== hw/afmc_top.sv
// sample buffer with four buffering policies and wishbone registers
//
// Added by the designer: the Wishbone register port and the register offsets.
`include "afmc_map.svh"
`default_nettype none
module afmc_top #(
  parameter int DEPTH = 512
) (
  // clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // sensor side
  input  wire afmc_pkg::afmc_sample_t sample_i,
  input  wire logic              activity_i,
  input  wire logic              measure_i,
  // interrupts
  output logic                   level_threshold_irq_o,
  output logic                   irq_o
);
  import afmc_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int EW = AW + 1;
  localparam logic [EW-1:0] FULL_N = EW'(DEPTH);

  // channels placed in the buffer per sample set
  function automatic logic [2:0] chan_count(input logic [3:0] sel);
    case (sel)
      4'h0:                      chan_count = 3'h3;
      4'h1, 4'h2, 4'h3:          chan_count = 3'h1;
      4'h4, 4'h8:                chan_count = 3'h4;
      4'h5, 4'h6, 4'h7,
      4'h9, 4'hA, 4'hB:          chan_count = 3'h2;
      default:                   chan_count = 3'h0; // reserved codes hold none
    endcase
  endfunction

  // register and pointer state
  afmc_ctrl_t      ctrl_q, ctrl_d;
  logic [7:0]      cnt_lo_q, cnt_lo_d;
  logic [2:0]      status_q, status_d;
  logic [2:0]      mask_q, mask_d;
  logic [AW-1:0]   wr_ptr_q, wr_ptr_d;
  logic [AW-1:0]   rd_ptr_q, rd_ptr_d;
  logic [EW-1:0]   entries_q, entries_d;
  afmc_trig_t      trig_q, trig_d;
  logic            lvl_q, lvl_d;
  logic            irq_d;
  logic            ack_d;
  logic [31:0]     dat_d;
  logic [15:0]     mem_q [DEPTH];

  // decode and derived terms
  logic            req, wr_en, rd_en;
  logic [5:0]      idx;
  logic [8:0]      set_cnt;
  logic [11:0]     thr;
  logic            full, reach, push, pop, drop, lost, lvl_now;

  assign idx     = wb_adr_i[7:2];
  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en   = req && wb_we_i && wb_sel_i[0];
  assign rd_en   = req && !wb_we_i;
  assign set_cnt = {ctrl_q.cnt_msb, cnt_lo_q};
  assign thr     = 12'(set_cnt) * 12'(chan_count(ctrl_q.chan_sel));
  assign full    = (entries_q == FULL_N);
  assign reach   = (12'(entries_q) >= thr);

  // policy decisions for this cycle
  always_comb begin
    pop  = rd_en && (idx == `AFMC_IDX_DATA) && (entries_q != '0);
    push = 1'b0;
    drop = 1'b0;
    lost = 1'b0;
    trig_d = trig_q;
    case (ctrl_q.mode)
      `AFMC_MODE_KEEP: begin
        push = sample_i.valid && (!full || pop);
        lost = sample_i.valid && !push;
      end
      `AFMC_MODE_STREAM: begin
        push = sample_i.valid;
        drop = sample_i.valid && full && !pop;
        lost = drop;
      end
      `AFMC_MODE_TRIG: begin
        case (trig_q)
          TRIG_ARMED: begin
            // pre-event history bounded by the set count
            push = sample_i.valid;
            drop = sample_i.valid && (reach || full) && !pop;
            if (activity_i) begin
              trig_d = TRIG_FILL;
            end
          end
          TRIG_FILL: begin
            push = sample_i.valid && !full;
            if (!pop && (full || (push && entries_q == FULL_N - EW'(1)))) begin
              trig_d = TRIG_DONE;
            end
          end
          TRIG_DONE: begin
            // one shot: rearm only once the host has read
            if (pop) begin
              trig_d = TRIG_ARMED;
            end
          end
          default: trig_d = TRIG_ARMED;
        endcase
      end
      default: begin
        // disabled: nothing is stored and nothing is held
        pop    = 1'b0;
        trig_d = TRIG_ARMED;
      end
    endcase
  end

  // pointers and level condition
  always_comb begin
    if (ctrl_q.mode == `AFMC_MODE_OFF) begin
      wr_ptr_d  = '0;
      rd_ptr_d  = '0;
      entries_d = '0;
      lvl_d     = 1'b0;
    end else begin
      wr_ptr_d  = push ? AW'(wr_ptr_q + 1'b1) : wr_ptr_q;
      rd_ptr_d  = (pop || drop) ? AW'(rd_ptr_q + 1'b1) : rd_ptr_q;
      entries_d = EW'(entries_q + EW'(push) - EW'(pop) - EW'(drop));
      if (ctrl_q.mode == `AFMC_MODE_TRIG) begin
        lvl_d = (trig_d == TRIG_DONE);
      end else begin
        lvl_d = reach;
      end
    end
  end
  assign lvl_now = lvl_d;

  // register writes, sticky status with set over clear, read mux
  always_comb begin
    ctrl_d   = ctrl_q;
    cnt_lo_d = cnt_lo_q;
    mask_d   = mask_q;
    status_d = status_q;
    if (wr_en) begin
      case (idx)
        `AFMC_IDX_CTRL: begin
          ctrl_d.chan_sel = wb_dat_i[6:3];
          ctrl_d.cnt_msb  = wb_dat_i[2];
          // policy frozen while measuring
          if (!measure_i) begin
            ctrl_d.mode = wb_dat_i[1:0];
          end
        end
        `AFMC_IDX_CNT_LO: cnt_lo_d = wb_dat_i[7:0];
        `AFMC_IDX_STATUS: status_d = status_q & ~wb_dat_i[2:0];
        `AFMC_IDX_MASK:   mask_d   = wb_dat_i[2:0];
        default: ;
      endcase
    end
    if (lvl_now && !lvl_q) begin
      status_d[`AFMC_ST_LEVEL] = 1'b1;
    end
    if (lost) begin
      status_d[`AFMC_ST_OVERRUN] = 1'b1;
    end
    if (trig_d == TRIG_DONE && trig_q != TRIG_DONE) begin
      status_d[`AFMC_ST_CAPTURED] = 1'b1;
    end
    irq_d = |(status_d & mask_d);
    ack_d = req;
    dat_d = wb_dat_o;
    if (rd_en) begin
      case (idx)
        `AFMC_IDX_CTRL:    dat_d = {24'h0, ctrl_q};
        `AFMC_IDX_CNT_LO:  dat_d = {24'h0, cnt_lo_q};
        `AFMC_IDX_STATUS:  dat_d = {29'h0, status_q};
        `AFMC_IDX_MASK:    dat_d = {29'h0, mask_q};
        `AFMC_IDX_DATA:    dat_d = pop ? {16'h0, mem_q[rd_ptr_q]} : 32'h0;
        `AFMC_IDX_ENTRIES: dat_d = 32'(entries_q);
        default:           dat_d = 32'h0;
      endcase
    end
  end

  // state registers; ce_i low freezes everything
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q                <= `AFMC_RST_CTRL;
      cnt_lo_q              <= `AFMC_RST_CNT_LO;
      status_q              <= 3'h0;
      mask_q                <= `AFMC_RST_MASK;
      wr_ptr_q              <= '0;
      rd_ptr_q              <= '0;
      entries_q             <= '0;
      trig_q                <= TRIG_ARMED;
      lvl_q                 <= 1'b0;
      level_threshold_irq_o <= 1'b0;
      irq_o                 <= 1'b0;
      wb_ack_o              <= 1'b0;
      wb_dat_o              <= 32'h0;
    end else if (ce_i) begin
      ctrl_q                <= ctrl_d;
      cnt_lo_q              <= cnt_lo_d;
      status_q              <= status_d;
      mask_q                <= mask_d;
      wr_ptr_q              <= wr_ptr_d;
      rd_ptr_q              <= rd_ptr_d;
      entries_q             <= entries_d;
      trig_q                <= trig_d;
      lvl_q                 <= lvl_d;
      level_threshold_irq_o <= lvl_d;
      irq_o                 <= irq_d;
      wb_ack_o              <= ack_d;
      wb_dat_o              <= dat_d;
    end
  end

  // sample storage, no reset needed for the array
  always_ff @(posedge clk_i) begin
    if (ce_i && push && ctrl_q.mode != `AFMC_MODE_OFF) begin
      mem_q[wr_ptr_q] <= sample_i.data;
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  a_keep_stops_full: assert property (
    ctrl_q.mode == `AFMC_MODE_KEEP && full && sample_i.valid && !pop
    |=> wr_ptr_q == $past(wr_ptr_q) && full)
    else $error("keep-oldest stored into a full buffer");
  a_keep_resume_read: assert property (
    ctrl_q.mode == `AFMC_MODE_KEEP && full && sample_i.valid && pop
    |=> full && wr_ptr_q != $past(wr_ptr_q))
    else $error("keep-oldest did not refill the freed entry");
  a_stream_drop_old: assert property (
    ctrl_q.mode == `AFMC_MODE_STREAM && full && sample_i.valid && !pop
    |=> full && rd_ptr_q == AW'($past(rd_ptr_q) + 1'b1))
    else $error("stream did not drop the oldest entry");
  a_stream_level_up: assert property (
    ctrl_q.mode == `AFMC_MODE_STREAM && ctrl_d.mode == `AFMC_MODE_STREAM
    && reach |=> level_threshold_irq_o)
    else $error("stream level threshold not raised");
  a_count_times_chan: assert property (
    ctrl_q.chan_sel == 4'h0 && set_cnt == 9'h002 |-> thr == 12'h006)
    else $error("set count not scaled by channel count");
  a_pretrig_bounded: assert property (
    ctrl_q.mode == `AFMC_MODE_TRIG && trig_q == TRIG_ARMED
    && $stable(thr) && 12'(entries_q) <= thr |=> 12'(entries_q) <= thr)
    else $error("pre-event history exceeds set count");
  a_trig_done_level: assert property (
    ctrl_q.mode == `AFMC_MODE_TRIG && trig_q == TRIG_FILL
    && trig_d == TRIG_DONE ##1 ctrl_q.mode == `AFMC_MODE_TRIG
    |-> trig_q == TRIG_DONE && level_threshold_irq_o && full)
    else $error("capture end did not raise level threshold");
  a_trig_hold_noread: assert property (
    ctrl_q.mode == `AFMC_MODE_TRIG && ctrl_d.mode == `AFMC_MODE_TRIG
    && trig_q == TRIG_DONE && !pop |=> trig_q == TRIG_DONE)
    else $error("trigger rearmed without a buffer read");
  a_off_idle: assert property (
    ctrl_q.mode == `AFMC_MODE_OFF [*2]
    |-> entries_q == '0 && !level_threshold_irq_o)
    else $error("disabled policy holds samples or level");

  c_stream_level: cover property (
    ctrl_q.mode == `AFMC_MODE_STREAM && level_threshold_irq_o);
  c_keep_full: cover property (
    ctrl_q.mode == `AFMC_MODE_KEEP && full && sample_i.valid);
  c_trig_done: cover property (trig_q == TRIG_FILL ##1 trig_q == TRIG_DONE);
endmodule // afmc_top
`default_nettype wire

// ===== test/afmc_sensor_model.sv
// sample source standing in for the sensor conversion path
`default_nettype none
module afmc_sensor_model (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // one sample per cycle while high
  input  wire logic              go_i,
  // sample stream into the buffer
  output afmc_pkg::afmc_sample_t sample_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import afmc_pkg::*;
  logic [15:0] seq_q;
  // idle data flips so a stale word is never mistaken for a sample
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_q    <= 16'h1000;
      sample_o <= '0;
    end else begin
      sample_o.valid <= go_i;
      sample_o.data  <= go_i ? seq_q : ~sample_o.data;
      if (go_i) seq_q <= seq_q + 16'h0001;
    end
  end
endmodule // afmc_sensor_model
`default_nettype wire

// ===== test/tb_afmc_top.sv
// self-checking bench for the sample buffer control block
`include "afmc_map.svh"
`default_nettype none
module tb_afmc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import afmc_pkg::*;
  logic         clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
  logic         we = 1'b0, go = 1'b0, act = 1'b0, meas = 1'b0, ce = 1'b1;
  logic [7:0]   adr = 8'h00;
  logic [31:0]  wdat = 32'h0, dat_o, rd;
  logic         ack, lvl, irq;
  afmc_sample_t smp;
  int           error_cnt = 0, checked = 0, seq = 0, s0;
  // 250 MHz clock
  always #2 clk_i = ~clk_i;
  afmc_top #(.DEPTH(8)) afmc_top_inst (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_sel_i(4'hF), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .sample_i(smp), .activity_i(act), .measure_i(meas),
    .level_threshold_irq_o(lvl), .irq_o(irq));
  afmc_sensor_model afmc_sensor_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .go_i(go), .sample_o(smp));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  // classic cycle held until ack; release only at the ack edge
  task automatic wb(input logic w, input logic [5:0] ix, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'h0};
    wdat <= {24'h0, d};
    // only the watchdog ends a wait that never sees ack
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic rchk(input logic [5:0] ix, input logic [31:0] e, string nm);
    wb(1'b0, ix, 8'h00);
    chk(nm, e, rd);
  endtask
  task automatic push(input int n);
    @(posedge clk_i);
    go <= 1'b1;
    repeat (n) @(posedge clk_i);
    go <= 1'b0;
    repeat (4) @(posedge clk_i);
    seq += n;
  endtask
  task automatic t_reset();
    rchk(`AFMC_IDX_CTRL, 32'h00, "ctrl");
    rchk(`AFMC_IDX_CNT_LO, 32'h80, "cnt_lo");
    rchk(`AFMC_IDX_MASK, 32'h00, "mask");
    rchk(`AFMC_IDX_STATUS, 32'h00, "status");
    rchk(6'h00, 32'h00, "unmapped");
    meas <= 1'b1;
    wb(1'b1, `AFMC_IDX_CTRL, 8'h05);
    rchk(`AFMC_IDX_CTRL, 32'h04, "ctrl_meas");
    meas <= 1'b0;
    wb(1'b1, `AFMC_IDX_CTRL, 8'h00);
    $display("test reset done");
  endtask
  // three axes, count 2: threshold six entries
  task automatic t_keep();
    s0 = seq;
    wb(1'b1, `AFMC_IDX_CNT_LO, 8'h02);
    wb(1'b1, `AFMC_IDX_CTRL, 8'h01);
    push(5);
    chk("lvl5", 32'h0, {31'h0, lvl});
    push(1);
    chk("lvl6", 32'h1, {31'h0, lvl});
    push(4);
    rchk(`AFMC_IDX_ENTRIES, 32'h8, "full");
    rchk(`AFMC_IDX_STATUS, 32'h3, "st");
    rchk(`AFMC_IDX_DATA, 32'h1000 + s0, "oldest");
    push(2);
    rchk(`AFMC_IDX_ENTRIES, 32'h8, "refill");
    rchk(`AFMC_IDX_DATA, 32'h1001 + s0, "next");
    $display("test keep done");
  endtask
  task automatic t_off();
    wb(1'b1, `AFMC_IDX_CTRL, 8'h00);
    push(3);
    rchk(`AFMC_IDX_ENTRIES, 32'h0, "off_ent");
    chk("off_lvl", 32'h0, {31'h0, lvl});
    rchk(`AFMC_IDX_DATA, 32'h0, "off_dat");
    $display("test off done");
  endtask
  task automatic t_stream();
    wb(1'b1, `AFMC_IDX_STATUS, 8'h07);
    wb(1'b1, `AFMC_IDX_MASK, 8'h01);
    wb(1'b1, `AFMC_IDX_CTRL, 8'h02);
    s0 = seq;
    push(10);
    rchk(`AFMC_IDX_ENTRIES, 32'h8, "s_ent");
    chk("s_lvl", 32'h1, {31'h0, lvl});
    chk("irq", 32'h1, {31'h0, irq});
    rchk(`AFMC_IDX_DATA, 32'h1002 + s0, "s_old");
    wb(1'b1, `AFMC_IDX_STATUS, 8'h01);
    chk("irq_clr", 32'h0, {31'h0, irq});
    // enable low: samples arrive but the frozen core keeps its count
    ce <= 1'b0;
    push(3);
    ce <= 1'b1;
    rchk(`AFMC_IDX_ENTRIES, 32'h7, "ce_hold");
    $display("test stream done");
  endtask
  // one channel, count 1: a single pre-event sample kept
  task automatic t_trig();
    wb(1'b1, `AFMC_IDX_CTRL, 8'h00);
    wb(1'b1, `AFMC_IDX_MASK, 8'h00);
    wb(1'b1, `AFMC_IDX_CNT_LO, 8'h01);
    wb(1'b1, `AFMC_IDX_CTRL, 8'h0B);
    wb(1'b1, `AFMC_IDX_STATUS, 8'h07);
    s0 = seq;
    push(3);
    rchk(`AFMC_IDX_ENTRIES, 32'h1, "pre");
    @(posedge clk_i);
    act <= 1'b1;
    @(posedge clk_i);
    act <= 1'b0;
    push(10);
    rchk(`AFMC_IDX_ENTRIES, 32'h8, "t_ent");
    chk("t_lvl", 32'h1, {31'h0, lvl});
    wb(1'b0, `AFMC_IDX_STATUS, 8'h00);
    chk("capt", 32'h4, rd & 32'h4);
    wb(1'b1, `AFMC_IDX_STATUS, 8'h04);
    // a second event before any read must not capture again
    @(posedge clk_i);
    act <= 1'b1;
    @(posedge clk_i);
    act <= 1'b0;
    push(2);
    wb(1'b0, `AFMC_IDX_STATUS, 8'h00);
    chk("no_rearm", 32'h0, rd & 32'h4);
    rchk(`AFMC_IDX_DATA, 32'h1002 + s0, "t_old");
    $display("test trig done");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_keep();
    t_off();
    t_stream();
    t_trig();
    print_verdict();
  end
  // watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    print_verdict();
  end
endmodule // tb_afmc_top
`default_nettype wire
